// *** rtl/swdc_pkg.sv ***
// constants for the standby wake detect configuration block
package swdc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_MODE_A = 8'h00;
  localparam logic [7:0] OFS_MODE_B = 8'h04;
  localparam logic [7:0] OFS_CLEAR = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  // ----------------------------------------
  // lane layout
  // ----------------------------------------
  localparam int NUM_CH = 8;
  localparam int CH_PER_REG = 4;
  localparam int LANE_W = 8;
  localparam int COND_LSB = 4;
  localparam int COND_W = 3;
  localparam int EST_LSB = 2;
  localparam int EST_W = 2;
  localparam int EN_BIT = 0;
  // ----------------------------------------
  // detection conditions and edge record
  // ----------------------------------------
  localparam logic [2:0] COND_LOW = 3'h0;
  localparam logic [2:0] COND_HIGH = 3'h1;
  localparam logic [2:0] COND_FALL = 3'h2;
  localparam logic [2:0] COND_RISE = 3'h3;
  localparam logic [2:0] COND_BOTH = 3'h4;
  localparam logic [2:0] COND_RESET = COND_FALL;
  localparam logic [1:0] EST_NONE = 2'h0;
  localparam logic [1:0] EST_RISE = 2'h1;
  localparam logic [1:0] EST_FALL = 2'h2;
endpackage

// *** rtl/swdc_top.sv ***
// standby wake detect configuration, detection and status
`timescale 1ns/1ps
module swdc_top (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [swdc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [swdc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [swdc_pkg::NUM_CH-1:0] wake_line_i,
  output logic [swdc_pkg::DATA_W-1:0] rdata_o,
  output logic wake_req_o,
  output logic irq_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [2:0] cond_ff [swdc_pkg::NUM_CH];
  logic [1:0] est_ff [swdc_pkg::NUM_CH];
  logic [swdc_pkg::NUM_CH-1:0] en_ff;
  logic [swdc_pkg::NUM_CH-1:0] sync1_ff;
  logic [swdc_pkg::NUM_CH-1:0] sync2_ff;
  logic [swdc_pkg::NUM_CH-1:0] prev_ff;
  logic [swdc_pkg::NUM_CH-1:0] pending_ff;
  logic [swdc_pkg::NUM_CH-1:0] irq_en_ff;
  logic [swdc_pkg::DATA_W-1:0] rdata_ff;
  logic wake_req_ff;
  logic irq_ff;
  logic [swdc_pkg::NUM_CH-1:0] rise;
  logic [swdc_pkg::NUM_CH-1:0] fall;
  logic [swdc_pkg::NUM_CH-1:0] hit;
  logic [swdc_pkg::NUM_CH-1:0] clr;
  logic [swdc_pkg::NUM_CH-1:0] nxt_pending;
  logic [swdc_pkg::DATA_W-1:0] nxt_rdata;
  logic wr_a;
  logic wr_b;

  assign wr_a = wr_i && (addr_i == swdc_pkg::OFS_MODE_A);
  assign wr_b = wr_i && (addr_i == swdc_pkg::OFS_MODE_B);
  assign clr = (wr_i && (addr_i == swdc_pkg::OFS_CLEAR)) ? wdata_i[swdc_pkg::NUM_CH-1:0] : '0;

  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  // two-stage sync
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= wake_line_i;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  assign rise = sync2_ff & ~prev_ff;
  assign fall = ~sync2_ff & prev_ff;

  // ----------------------------------------
  // per channel mode, detection and edge record
  // ----------------------------------------
  for (genvar i = 0; i < swdc_pkg::NUM_CH; i++) begin : g_ch
    localparam int LANE = i % swdc_pkg::CH_PER_REG;
    localparam int CBIT = LANE * swdc_pkg::LANE_W + swdc_pkg::COND_LSB;
    localparam int EBIT = LANE * swdc_pkg::LANE_W + swdc_pkg::EN_BIT;
    logic sel;
    logic raw;
    assign sel = (i < swdc_pkg::CH_PER_REG) ? wr_a : wr_b;

    always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
        cond_ff[i] <= swdc_pkg::COND_RESET;
        en_ff[i] <= 1'b0;
      end else if (sel) begin
        cond_ff[i] <= wdata_i[CBIT +: swdc_pkg::COND_W];
        en_ff[i] <= wdata_i[EBIT];
      end
    end

    always_comb begin
      raw = 1'b0;
      case (cond_ff[i])
        swdc_pkg::COND_LOW: raw = ~sync2_ff[i];
        swdc_pkg::COND_HIGH: raw = sync2_ff[i];
        swdc_pkg::COND_FALL: raw = fall[i];
        swdc_pkg::COND_RISE: raw = rise[i];
        swdc_pkg::COND_BOTH: raw = rise[i] | fall[i];
        default: raw = 1'b0;
      endcase
    end

    assign hit[i] = raw & en_ff[i];

    always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
        est_ff[i] <= swdc_pkg::EST_NONE;
      end else begin
        est_ff[i] <= (clr[i] ? swdc_pkg::EST_NONE : est_ff[i])
                   | ((en_ff[i] && cond_ff[i] == swdc_pkg::COND_BOTH) ?
                      ({fall[i], 1'b0} | {1'b0, rise[i]}) : swdc_pkg::EST_NONE);
      end
    end
  end

  // ----------------------------------------
  // pending status, interrupt and wake request
  // ----------------------------------------
  assign nxt_pending = (pending_ff & ~clr) | hit;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pending_ff <= '0;
    end else begin
      pending_ff <= nxt_pending;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_en_ff <= '0;
    end else if (wr_i && addr_i == swdc_pkg::OFS_IRQ_EN) begin
      irq_en_ff <= wdata_i[swdc_pkg::NUM_CH-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wake_req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      wake_req_ff <= |hit;
      irq_ff <= |(pending_ff & irq_en_ff);
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_comb begin
    nxt_rdata = '0;
    case (addr_i)
      swdc_pkg::OFS_MODE_A: begin
        for (int l = 0; l < swdc_pkg::CH_PER_REG; l++) begin
          nxt_rdata[l*swdc_pkg::LANE_W+swdc_pkg::COND_LSB +: swdc_pkg::COND_W] = cond_ff[l];
          nxt_rdata[l*swdc_pkg::LANE_W+swdc_pkg::EST_LSB +: swdc_pkg::EST_W] = est_ff[l];
          nxt_rdata[l*swdc_pkg::LANE_W+swdc_pkg::EN_BIT] = en_ff[l];
        end
      end
      swdc_pkg::OFS_MODE_B: begin
        for (int l = 0; l < swdc_pkg::CH_PER_REG; l++) begin
          nxt_rdata[l*swdc_pkg::LANE_W+swdc_pkg::COND_LSB +: swdc_pkg::COND_W] =
            cond_ff[l+swdc_pkg::CH_PER_REG];
          nxt_rdata[l*swdc_pkg::LANE_W+swdc_pkg::EST_LSB +: swdc_pkg::EST_W] =
            est_ff[l+swdc_pkg::CH_PER_REG];
          nxt_rdata[l*swdc_pkg::LANE_W+swdc_pkg::EN_BIT] = en_ff[l+swdc_pkg::CH_PER_REG];
        end
      end
      swdc_pkg::OFS_STATUS: nxt_rdata[swdc_pkg::NUM_CH-1:0] = pending_ff;
      swdc_pkg::OFS_IRQ_EN: nxt_rdata[swdc_pkg::NUM_CH-1:0] = irq_en_ff;
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else if (rd_i) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata_o = rdata_ff;
  assign wake_req_o = wake_req_ff;
  assign irq_o = irq_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_LANE_A: assert property (rd_i && addr_i == swdc_pkg::OFS_MODE_A |=>
    rdata_o[30:28] == $past(cond_ff[3]) && rdata_o[24] == $past(en_ff[3]) && !rdata_o[31])
    else $error("mode a top lane readback wrong");

  AST_LOW_LEVEL: assert property (en_ff[6] && cond_ff[6] == swdc_pkg::COND_LOW && !sync2_ff[6]
    |=> pending_ff[6] && wake_req_o)
    else $error("low level not detected");

  AST_HIGH_LEVEL: assert property (en_ff[7] && cond_ff[7] == swdc_pkg::COND_HIGH && sync2_ff[7]
    |=> pending_ff[7] && wake_req_o)
    else $error("high level not detected");

  AST_FALL_ONLY: assert property (en_ff[5] && cond_ff[5] == swdc_pkg::COND_FALL && !fall[5]
    && !pending_ff[5] && !clr[5] |=> !pending_ff[5])
    else $error("fall mode fired without falling edge");

  AST_BAD_CODE: assert property (cond_ff[1] > swdc_pkg::COND_BOTH |-> !hit[1])
    else $error("prohibited code detected a line");

  AST_RISE_ONLY: assert property (en_ff[1] && cond_ff[1] == swdc_pkg::COND_RISE && !rise[1]
    && !pending_ff[1] && !clr[1] |=> !pending_ff[1])
    else $error("rise mode fired without rising edge");

  AST_EST_RISE: assert property (en_ff[0] && cond_ff[0] == swdc_pkg::COND_BOTH && rise[0]
    |=> est_ff[0][0])
    else $error("rising edge not recorded");

  AST_EST_FALL: assert property (en_ff[0] && cond_ff[0] == swdc_pkg::COND_BOTH && fall[0]
    |=> est_ff[0][1])
    else $error("falling edge not recorded");

  AST_EST_MODE: assert property (!(en_ff[2] && cond_ff[2] == swdc_pkg::COND_BOTH)
    |=> est_ff[2] == $past(est_ff[2]) || est_ff[2] == swdc_pkg::EST_NONE)
    else $error("edge record changed outside both-edge mode");

  AST_EST_CLEAR: assert property (clr[0] && !hit[0]
    |=> est_ff[0] == swdc_pkg::EST_NONE && !pending_ff[0])
    else $error("clear did not zero edge record");

  AST_CLR_PEND: assert property (clr[5] && !hit[5] |=> !pending_ff[5])
    else $error("clear did not drop pending");

  AST_SET_WINS: assert property (hit[6] && clr[6] |=> pending_ff[6])
    else $error("clear beat a new event");

  AST_PEND_HOLD: assert property (pending_ff[7] && !clr[7] |=> pending_ff[7])
    else $error("pending bit not sticky");

  AST_EN_GATE: assert property (!en_ff[3] && !pending_ff[3] |=> !pending_ff[3])
    else $error("disabled line set pending");

  AST_LANE_B: assert property (rd_i && addr_i == swdc_pkg::OFS_MODE_B |=>
    rdata_o[14:12] == $past(cond_ff[5]) && rdata_o[8] == $past(en_ff[5]))
    else $error("mode b lane readback wrong");

  AST_SYNC_LAT: assert property ($rose(wake_line_i[5]) ##1 wake_line_i[5] [*2]
    |-> ##1 sync2_ff[5])
    else $error("synchroniser latency wrong");

  AST_WAKE_IDLE: assert property (!(|hit) |=> !wake_req_o)
    else $error("wake request without a hit");

  AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data outside read cycle");

  AST_SPARE_A: assert property (rd_i && addr_i == swdc_pkg::OFS_MODE_A
    |=> !rdata_o[swdc_pkg::LANE_W-1] && !rdata_o[swdc_pkg::EN_BIT+1])
    else $error("mode a spare bits not zero");

  AST_SPARE_B: assert property (rd_i && addr_i == swdc_pkg::OFS_MODE_B
    |=> !rdata_o[swdc_pkg::DATA_W-1] && !rdata_o[swdc_pkg::LANE_W+1])
    else $error("mode b spare bits not zero");

  AST_RESET_VAL: assert property ($past(!rst_n_i) |-> cond_ff[6] == swdc_pkg::COND_RESET
    && !en_ff[6] && est_ff[6] == swdc_pkg::EST_NONE)
    else $error("reset values wrong");

  AST_IRQ: assert property (|(pending_ff & irq_en_ff) |=> irq_o)
    else $error("interrupt not raised");

  AST_IRQ_LOW: assert property (!(|(pending_ff & irq_en_ff)) |=> !irq_o)
    else $error("interrupt without enabled pending bit");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  COV_BOTH_EDGES: cover property (est_ff[0] == (swdc_pkg::EST_RISE | swdc_pkg::EST_FALL));
  COV_WAKE: cover property (wake_req_o ##1 irq_o);
  COV_CLEAR: cover property (pending_ff[0] ##1 clr[0] ##1 !pending_ff[0]);
  COV_RISE_MODE: cover property (en_ff[1] && cond_ff[1] == swdc_pkg::COND_RISE && rise[1]);
  COV_SET_WINS: cover property (hit[6] && clr[6]);

endmodule // swdc_top

// *** sim/swdc_pins_model.sv ***
// external wake pins standing in for the far side of the block
`timescale 1ns/1ps
module swdc_pins_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] level_i,
  output logic [7:0] wake_line_o
);
  // pins move just after the clock edge, held as levels
  always @(posedge sys_clk_i) begin
    wake_line_o <= level_i;
  end
endmodule // swdc_pins_model

// *** sim/test_standby_wake_detect_config.sv ***
// self-checking bench for the standby wake detect block
`timescale 1ns/1ps
module test_standby_wake_detect_config;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] pin_lvl = 8'h00;
  logic [7:0] wake_line;
  logic [31:0] rdata_o;
  logic wake_req_o;
  logic irq_o;
  int n_fail = 0;
  int n_checks = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  swdc_pins_model u_swdc_pins_model (.sys_clk_i(sys_clk_i), .level_i(pin_lvl), .wake_line_o(wake_line));
  swdc_top u_swdc_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .wake_line_i(wake_line), .rdata_o(rdata_o), .wake_req_o(wake_req_o), .irq_o(irq_o));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, rdata_o, exp);
  endtask
  task automatic pins(input logic [7:0] v, input int gap);
    @(posedge sys_clk_i);
    pin_lvl <= v;
    repeat (gap) @(posedge sys_clk_i);
  endtask
  task automatic wait_req();
    int k;
    for (k = 0; k < 20 && wake_req_o !== 1'b1; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (wake_req_o !== 1'b1) begin
      n_fail++;
      $display("BAD wake_req_o never rose");
      wrap_up();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(swdc_pkg::OFS_MODE_A, 32'h20202020, "mode_a reset");
    rd(swdc_pkg::OFS_MODE_B, 32'h20202020, "mode_b reset");
    rd(8'h14, 32'h0, "unmapped read");
    rd(swdc_pkg::OFS_STATUS, 32'h0, "status reset");
    $display("t_reset done");
  endtask
  task automatic t_readonly();
    // only legal condition codes are ever written
    wr(swdc_pkg::OFS_MODE_A, 32'h4C4C4C4C);
    rd(swdc_pkg::OFS_MODE_A, 32'h40404040, "edge bits ignore write");
    $display("t_readonly done");
  endtask
  task automatic t_both_edges();
    wr(swdc_pkg::OFS_MODE_A, 32'h00000040);
    wr(swdc_pkg::OFS_MODE_A, 32'h00000041);
    wr(swdc_pkg::OFS_IRQ_EN, 32'h00000001);
    pins(8'h01, 0);
    wait_req();
    rd(swdc_pkg::OFS_STATUS, 32'h01, "pending line0");
    rd(swdc_pkg::OFS_MODE_A, 32'h45, "edge rise");
    pins(8'h00, 0);
    wait_req();
    rd(swdc_pkg::OFS_MODE_A, 32'h4D, "edge both");
    chk("irq_o set", irq_o, 32'h1);
    wr(swdc_pkg::OFS_CLEAR, 32'h01);
    rd(swdc_pkg::OFS_STATUS, 32'h0, "pending cleared");
    rd(swdc_pkg::OFS_MODE_A, 32'h41, "edge cleared");
    chk("irq_o clear", irq_o, 32'h0);
    $display("t_both_edges done");
  endtask
  task automatic t_disabled_fall();
    wr(swdc_pkg::OFS_MODE_B, 32'h00002000);
    pins(8'h20, 6);
    pins(8'h00, 6);
    rd(swdc_pkg::OFS_STATUS, 32'h0, "disabled line5");
    wr(swdc_pkg::OFS_MODE_B, 32'h00002100);
    pins(8'h20, 6);
    rd(swdc_pkg::OFS_STATUS, 32'h0, "rise ignored in fall");
    pins(8'h00, 0);
    wait_req();
    rd(swdc_pkg::OFS_STATUS, 32'h20, "pending line5");
    rd(swdc_pkg::OFS_MODE_B, 32'h2100, "no edge record");
    wr(swdc_pkg::OFS_CLEAR, 32'h20);
    $display("t_disabled_fall done");
  endtask
  task automatic t_levels();
    wr(swdc_pkg::OFS_MODE_B, 32'h10000000);
    wr(swdc_pkg::OFS_MODE_B, 32'h11000000);
    pins(8'h80, 0);
    wait_req();
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("high level holds", wake_req_o, 32'h1);
    pins(8'hC0, 5);
    #1;
    chk("line7 still high", wake_req_o, 32'h1);
    pins(8'h00, 5);
    #1;
    chk("no level met", wake_req_o, 32'h0);
    wr(swdc_pkg::OFS_CLEAR, 32'h80);
    wr(swdc_pkg::OFS_MODE_B, 32'h11010000);
    wait_req();
    rd(swdc_pkg::OFS_STATUS, 32'h40, "low level line6");
    wr(swdc_pkg::OFS_CLEAR, 32'h40);
    rd(swdc_pkg::OFS_STATUS, 32'h40, "level event beats clear");
    $display("t_levels done");
  endtask
  task automatic t_mid_reset();
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk("rdata after reset", rdata_o, 32'h0);
    chk("wake after reset", wake_req_o, 32'h0);
    chk("irq after reset", irq_o, 32'h0);
    rd(swdc_pkg::OFS_MODE_B, 32'h20202020, "mode_b mid reset");
    rd(swdc_pkg::OFS_STATUS, 32'h0, "status mid reset");
    rd(swdc_pkg::OFS_IRQ_EN, 32'h0, "irq enable mid reset");
    $display("t_mid_reset done");
  endtask
  task automatic t_rise();
    wr(swdc_pkg::OFS_MODE_A, 32'h00003020);
    wr(swdc_pkg::OFS_MODE_A, 32'h00003120);
    pins(8'h02, 0);
    wait_req();
    rd(swdc_pkg::OFS_STATUS, 32'h02, "rise line1");
    chk("irq masked", irq_o, 32'h0);
    wr(swdc_pkg::OFS_IRQ_EN, 32'h00000002);
    rd(swdc_pkg::OFS_IRQ_EN, 32'h02, "irq enable line1");
    chk("irq unmasked", irq_o, 32'h1);
    wr(swdc_pkg::OFS_CLEAR, 32'h02);
    pins(8'h00, 6);
    rd(swdc_pkg::OFS_STATUS, 32'h0, "fall ignored in rise");
    chk("irq after clear", irq_o, 32'h0);
    rd(swdc_pkg::OFS_MODE_A, 32'h00003120, "rise mode no edge record");
    $display("t_rise done");
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_readonly();
    t_both_edges();
    t_disabled_fall();
    t_levels();
    t_mid_reset();
    t_rise();
    wrap_up();
  end
endmodule // test_standby_wake_detect_config
